/* File: jtid_params.svh */
`ifndef JTID_PARAMS_SVH
`define JTID_PARAMS_SVH

// ----------------------------------------------------------------
// Scan path geometry
// ----------------------------------------------------------------
`define JTID_IR_W 4
`define JTID_DR_W 32
`define JTID_PIN_W 32
`define JTID_MODE_W 3
`define JTID_IR_CAPTURE 4'h1

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define JTID_INS_EXTEST 4'h0
`define JTID_INS_SAMPLE 4'h1
`define JTID_INS_IDCODE 4'h2
`define JTID_INS_USERCODE 4'h3
`define JTID_INS_CHIP 4'h4
`define JTID_INS_OTP 4'h5
`define JTID_INS_BYPASS 4'hf

// ----------------------------------------------------------------
// Security register bits and usercode fields
// ----------------------------------------------------------------
`define JTID_SEC_NO_JTAG 0
`define JTID_SEC_NO_OTP 13
`define JTID_UID_HI 31
`define JTID_UID_LO 22
`define JTID_UNUSED_W 4
`define JTID_REV_W 18

// ----------------------------------------------------------------
// Identity defaults, values arbitrary
// ----------------------------------------------------------------
`define JTID_DEF_VERSION 4'h1
`define JTID_DEF_PART 16'h0abc
`define JTID_DEF_MAKER 11'h155
`define JTID_DEF_REV 18'h00123

`endif

/* File: jtid_pkg.sv */
`default_nettype none
`include "jtid_params.svh"

package jtid_pkg;

    // Every input arriving from outside core_clk except rst_n travels in this bundle
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
        logic chip_tdo;
        logic pll_lock;
        logic [`JTID_MODE_W-1:0] boot_mode;
        logic [`JTID_PIN_W-1:0] pin_in;
    } jtid_async_type;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } jtid_chip_tap_type;

endpackage

`default_nettype wire

/* File: jtid_sync2.sv */
`default_nettype none

module jtid_sync2 #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    meta_ff[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta_ff[i] <= d[i];
                    q[i] <= meta_ff[i];
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

/* File: jtid_tap.sv */
`default_nettype none
`include "jtid_params.svh"

module jtid_tap #(
    parameter logic [3:0] ID_VERSION = `JTID_DEF_VERSION,
    parameter logic [15:0] ID_PART = `JTID_DEF_PART,
    parameter logic [10:0] ID_MAKER = `JTID_DEF_MAKER,
    parameter logic [`JTID_REV_W-1:0] SILICON_REV = `JTID_DEF_REV
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [31:0] sec_reg,
    input wire logic pll_lock,
    input wire logic [`JTID_MODE_W-1:0] boot_mode,
    output logic chip_rst,
    output logic boot_start,
    output logic [`JTID_MODE_W-1:0] boot_mode_latched,
    output jtid_pkg::jtid_chip_tap_type chip_tap,
    input wire logic chip_tdo,
    input wire logic [`JTID_PIN_W-1:0] pin_in,
    output logic [`JTID_PIN_W-1:0] pin_out,
    output logic pin_test_oe,
    input wire logic [`JTID_DR_W-1:0] otp_rd_data,
    output logic otp_rd_en,
    output logic [`JTID_DR_W-1:0] otp_wr_data,
    output logic otp_wr_stb
);
    import jtid_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    jtid_async_type async_raw;
    jtid_async_type async_s;

    assign async_raw.tck = tck;
    assign async_raw.tms = tms;
    assign async_raw.tdi = tdi;
    assign async_raw.trst_n = trst_n;
    assign async_raw.chip_tdo = chip_tdo;
    assign async_raw.pll_lock = pll_lock;
    assign async_raw.boot_mode = boot_mode;
    assign async_raw.pin_in = pin_in;

    jtid_sync2 #(.W($bits(jtid_async_type))) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .d(async_raw),
        .q(async_s)
    );

    // ------------------------------------------------------------
    // Test clock edge detection
    // ------------------------------------------------------------
    logic tck_d_ff;
    wire tck_rise = async_s.tck & ~tck_d_ff;
    wire tck_fall = ~async_s.tck & tck_d_ff;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tck_d_ff <= 1'b0;
        end else begin
            tck_d_ff <= async_s.tck;
        end
    end

    // ------------------------------------------------------------
    // TAP controller
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        st_reset   = 16'h0001,
        st_idle    = 16'h0002,
        st_sel_dr  = 16'h0004,
        st_cap_dr  = 16'h0008,
        st_shf_dr  = 16'h0010,
        st_ex1_dr  = 16'h0020,
        st_pau_dr  = 16'h0040,
        st_ex2_dr  = 16'h0080,
        st_upd_dr  = 16'h0100,
        st_sel_ir  = 16'h0200,
        st_cap_ir  = 16'h0400,
        st_shf_ir  = 16'h0800,
        st_ex1_ir  = 16'h1000,
        st_pau_ir  = 16'h2000,
        st_ex2_ir  = 16'h4000,
        st_upd_ir  = 16'h8000
    } jtid_tap_state_type;

    jtid_tap_state_type state_ff;
    jtid_tap_state_type nxt_state;

    // Fused-off port and held test reset both pin the controller in reset
    wire tap_off = ~async_s.trst_n | sec_reg[`JTID_SEC_NO_JTAG];

    always_comb begin
        case (state_ff)
            st_reset:  nxt_state = async_s.tms ? st_reset : st_idle;
            st_idle:   nxt_state = async_s.tms ? st_sel_dr : st_idle;
            st_sel_dr: nxt_state = async_s.tms ? st_sel_ir : st_cap_dr;
            st_cap_dr: nxt_state = async_s.tms ? st_ex1_dr : st_shf_dr;
            st_shf_dr: nxt_state = async_s.tms ? st_ex1_dr : st_shf_dr;
            st_ex1_dr: nxt_state = async_s.tms ? st_upd_dr : st_pau_dr;
            st_pau_dr: nxt_state = async_s.tms ? st_ex2_dr : st_pau_dr;
            st_ex2_dr: nxt_state = async_s.tms ? st_upd_dr : st_shf_dr;
            st_upd_dr: nxt_state = async_s.tms ? st_sel_dr : st_idle;
            st_sel_ir: nxt_state = async_s.tms ? st_reset : st_cap_ir;
            st_cap_ir: nxt_state = async_s.tms ? st_ex1_ir : st_shf_ir;
            st_shf_ir: nxt_state = async_s.tms ? st_ex1_ir : st_shf_ir;
            st_ex1_ir: nxt_state = async_s.tms ? st_upd_ir : st_pau_ir;
            st_pau_ir: nxt_state = async_s.tms ? st_ex2_ir : st_pau_ir;
            st_ex2_ir: nxt_state = async_s.tms ? st_upd_ir : st_shf_ir;
            st_upd_ir: nxt_state = async_s.tms ? st_sel_dr : st_idle;
            default:   nxt_state = st_reset;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset || tap_off) begin
            state_ff <= st_reset;
        end else if (tck_rise) begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Instruction register and decode
    // ------------------------------------------------------------
    logic [`JTID_IR_W-1:0] ir_shift_ff;
    logic [`JTID_IR_W-1:0] ir_ff;

    wire ins_extest = (ir_ff == `JTID_INS_EXTEST);
    wire ins_sample = (ir_ff == `JTID_INS_SAMPLE);
    wire ins_idcode = (ir_ff == `JTID_INS_IDCODE);
    wire ins_user = (ir_ff == `JTID_INS_USERCODE);
    wire ins_chip = (ir_ff == `JTID_INS_CHIP);
    // OTP access collapses to bypass while the fuse forbids it
    wire ins_otp = (ir_ff == `JTID_INS_OTP) & ~sec_reg[`JTID_SEC_NO_OTP];
    wire ins_bscan = ins_extest | ins_sample;
    wire ins_wide = ins_bscan | ins_idcode | ins_user | ins_otp;
    wire ins_bypass = ~ins_wide & ~ins_chip;

    always_ff @(posedge core_clk) begin
        if (reset || tap_off) begin
            ir_shift_ff <= `JTID_IR_CAPTURE;
        end else if (tck_rise && state_ff == st_cap_ir) begin
            ir_shift_ff <= `JTID_IR_CAPTURE;
        end else if (tck_rise && state_ff == st_shf_ir) begin
            ir_shift_ff <= {async_s.tdi, ir_shift_ff[`JTID_IR_W-1:1]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || tap_off) begin
            ir_ff <= `JTID_INS_IDCODE;
        end else if (tck_fall && state_ff == st_reset) begin
            ir_ff <= `JTID_INS_IDCODE;
        end else if (tck_fall && state_ff == st_upd_ir) begin
            ir_ff <= ir_shift_ff;
        end
    end

    // ------------------------------------------------------------
    // Data register path
    // ------------------------------------------------------------
    wire [`JTID_DR_W-1:0] idcode_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    wire [`JTID_DR_W-1:0] user_word = {sec_reg[`JTID_UID_HI:`JTID_UID_LO],
                                       {`JTID_UNUSED_W{1'b0}}, SILICON_REV};

    logic [`JTID_DR_W-1:0] dr_shift_ff;
    logic [`JTID_DR_W-1:0] capture_word;

    always_comb begin
        capture_word = '0;
        if (ins_bscan) begin
            capture_word = async_s.pin_in;
        end else if (ins_idcode) begin
            capture_word = idcode_word;
        end else if (ins_user) begin
            capture_word = user_word;
        end else if (ins_otp) begin
            capture_word = otp_rd_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || tap_off) begin
            dr_shift_ff <= '0;
        end else if (tck_rise && state_ff == st_cap_dr) begin
            dr_shift_ff <= capture_word;
        end else if (tck_rise && state_ff == st_shf_dr) begin
            if (ins_wide) begin
                dr_shift_ff <= {async_s.tdi, dr_shift_ff[`JTID_DR_W-1:1]};
            end else if (ins_bypass) begin
                dr_shift_ff[0] <= async_s.tdi;
            end
        end
    end

    // ------------------------------------------------------------
    // Boundary scan update and OTP writes
    // ------------------------------------------------------------
    wire dr_update = tck_fall && state_ff == st_upd_dr;

    always_ff @(posedge core_clk) begin
        if (reset || tap_off) begin
            pin_out <= '0;
            pin_test_oe <= 1'b0;
        end else begin
            if (dr_update && ins_bscan) begin
                pin_out <= dr_shift_ff;
            end
            pin_test_oe <= ins_extest;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || tap_off) begin
            otp_wr_data <= '0;
            otp_wr_stb <= 1'b0;
            otp_rd_en <= 1'b0;
        end else begin
            otp_wr_stb <= dr_update & ins_otp;
            if (dr_update && ins_otp) begin
                otp_wr_data <= dr_shift_ff;
            end
            otp_rd_en <= ins_otp;
        end
    end

    // ------------------------------------------------------------
    // Chip-level TAP forwarding
    // ------------------------------------------------------------
    // The inner TAP follows TMS all the time but only clocks while selected,
    // so it parks in its current state when another register is in use.
    always_ff @(posedge core_clk) begin
        if (reset || tap_off) begin
            chip_tap <= '0;
        end else begin
            chip_tap.tck <= async_s.tck & ins_chip;
            chip_tap.tms <= async_s.tms;
            chip_tap.tdi <= async_s.tdi;
            chip_tap.trst_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // TDO, changes on the falling test clock
    // ------------------------------------------------------------
    wire shifting = (state_ff == st_shf_dr) | (state_ff == st_shf_ir);
    wire tdo_src = (state_ff == st_shf_ir) ? ir_shift_ff[0] :
                   ins_chip ? async_s.chip_tdo : dr_shift_ff[0];

    always_ff @(posedge core_clk) begin
        if (reset || tap_off) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo <= tdo_src;
            tdo_oe <= shifting;
        end
    end

    // ------------------------------------------------------------
    // Chip reset and boot sequencing
    // ------------------------------------------------------------
    // Assertion must not wait for the clock, so this pair clears
    // asynchronously; release is still synchronised.
    logic rel_meta_ff;
    logic rel_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rel_meta_ff <= 1'b0;
            rel_ff <= 1'b0;
        end else begin
            rel_meta_ff <= 1'b1;
            rel_ff <= rel_meta_ff;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_rst <= 1'b1;
        end else begin
            chip_rst <= ~rel_ff | reset;
        end
    end

    typedef enum logic [2:0] {
        bt_hold = 3'h1,
        bt_lock = 3'h2,
        bt_run  = 3'h4
    } jtid_boot_state_type;

    jtid_boot_state_type boot_ff;
    jtid_boot_state_type nxt_boot;

    always_comb begin
        case (boot_ff)
            bt_hold: nxt_boot = bt_lock;
            bt_lock: nxt_boot = async_s.pll_lock ? bt_run : bt_lock;
            bt_run:  nxt_boot = bt_run;
            default: nxt_boot = bt_hold;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset || !rel_ff) begin
            boot_ff <= bt_hold;
            boot_start <= 1'b0;
        end else begin
            boot_ff <= nxt_boot;
            boot_start <= (boot_ff == bt_lock) & async_s.pll_lock;
        end
    end

    // Boot strap is caught once, just after the reset release
    always_ff @(posedge core_clk) begin
        if (reset) begin
            boot_mode_latched <= '0;
        end else if (boot_ff == bt_hold && rel_ff) begin
            boot_mode_latched <= async_s.boot_mode;
        end
    end

endmodule

`default_nettype wire

/* File: jtid_monitor.sv */
`default_nettype none
// --------------------------------------------------------
// Port checks for the test port and the boot sequencer
// --------------------------------------------------------
module jtid_monitor (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic rst_n,
    input wire logic trst_n,
    input wire logic [31:0] sec_reg,
    input wire logic pll_lock,
    input wire logic chip_rst,
    input wire logic boot_start,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic pin_test_oe,
    input wire logic otp_rd_en,
    input wire logic otp_wr_stb,
    input wire jtid_pkg::jtid_chip_tap_type chip_tap
);
    timeunit 1ns;
    timeprecision 100ps;
    import jtid_pkg::*;

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence pin_release_s;
        $rose(rst_n);
    endsequence
    sequence chip_running_s;
        ##[1:6] !chip_rst;
    endsequence
    // Six samples cover the pin synchroniser plus the registered outputs
    sequence trst_held_s;
        !trst_n [*6];
    endsequence

    chip_hold_a: assert property (!rst_n |-> chip_rst)
        else $error("chip reset low while reset pin asserted");
    chip_release_a: assert property (pin_release_s |-> chip_running_s)
        else $error("chip reset did not release");
    boot_gate_a: assert property (boot_start |-> !chip_rst && $past(pll_lock, 2))
        else $error("boot started before lock or in reset");
    boot_pulse_a: assert property (boot_start |=> !boot_start)
        else $error("boot start longer than one cycle");
    test_reset_a: assert property (trst_held_s |-> !tdo_oe && !tdo && !pin_test_oe
        && !otp_rd_en && !chip_tap.tck) else $error("test logic active under test reset");
    secure_off_a: assert property (sec_reg[0] [*4] |-> !tdo_oe && !pin_test_oe
        && !otp_rd_en && !chip_tap.tck) else $error("test port active while locked");
    otp_block_a: assert property (sec_reg[13] [*4] |-> !otp_rd_en && !otp_wr_stb)
        else $error("fuse access while blocked");
    otp_strobe_a: assert property (otp_wr_stb |=> !otp_wr_stb)
        else $error("fuse write strobe longer than one cycle");
endmodule

bind jtid_tap jtid_monitor u_mon (
    .core_clk(core_clk), .reset(reset), .rst_n(rst_n), .trst_n(trst_n),
    .sec_reg(sec_reg), .pll_lock(pll_lock), .chip_rst(chip_rst), .boot_start(boot_start),
    .tdo(tdo), .tdo_oe(tdo_oe), .pin_test_oe(pin_test_oe), .otp_rd_en(otp_rd_en),
    .otp_wr_stb(otp_wr_stb), .chip_tap(chip_tap)
);
`default_nettype wire

/* File: jtid_dbg.sv */
`default_nettype none
// --------------------------------------------------------
// Debug probe driving the test pins
// --------------------------------------------------------
module jtid_dbg (
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b0;
    end

    // Test reset stays low well past the minimum before any change
    task automatic set_trst(input logic v);
        #150 trst_n = v;
    endtask

    // One test clock period; tdo is taken just before the fall that may change it
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #160 tck = 1'b1;
        #150 o = tdo;
        #10 tck = 1'b0;
    endtask

    // Outside shifting the data line toggles so no stale level looks valid
    task automatic walk(input logic [7:0] path, input int n);
        logic o;
        #3;
        for (int i = 0; i < n; i++) begin
            step(path[i], ~tdi, o);
        end
    endtask

    task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        walk(8'h01, 2);
    endtask

    task automatic ir(input logic [3:0] code, output logic [31:0] cap);
        walk(8'h03, 4);
        scan(4, {28'h0, code}, cap);
    endtask

    task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
        walk(8'h01, 3);
        scan(n, din, dout);
    endtask
endmodule
`default_nettype wire

/* File: tb.sv */
`default_nettype none
`include "jtid_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import jtid_pkg::*;

    localparam logic [31:0] ID_EXP = {`JTID_DEF_VERSION, `JTID_DEF_PART, `JTID_DEF_MAKER, 1'b1};
    logic core_clk, reset, rst_n, pll_lock, chip_tdo, chip_rst, boot_start, tdo, tdo_oe;
    logic pin_test_oe, otp_rd_en, otp_wr_stb, tck, tms, tdi, trst_n;
    logic [31:0] sec_reg, pin_in, pin_out, otp_rd_data, otp_wr_data, v;
    logic [2:0] boot_mode, boot_mode_latched;
    jtid_chip_tap_type chip_tap;
    int errors, n_checks, n0;
    int chip_rises = 0;
    int stb_count = 0;
    logic chip_tck_d = 1'b0;

    jtid_tap DUT (
        .core_clk(core_clk), .reset(reset), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .sec_reg(sec_reg), .pll_lock(pll_lock),
        .boot_mode(boot_mode), .chip_rst(chip_rst), .boot_start(boot_start),
        .boot_mode_latched(boot_mode_latched), .chip_tap(chip_tap), .chip_tdo(chip_tdo),
        .pin_in(pin_in), .pin_out(pin_out), .pin_test_oe(pin_test_oe),
        .otp_rd_data(otp_rd_data), .otp_rd_en(otp_rd_en), .otp_wr_data(otp_wr_data),
        .otp_wr_stb(otp_wr_stb)
    );
    jtid_dbg u_dbg (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Inner test clock rises and fuse write strobes, counted off the sampling edge
    always @(negedge core_clk) begin
        chip_tck_d <= chip_tap.tck;
        if (chip_tap.tck && !chip_tck_d) begin
            chip_rises <= chip_rises + 1;
        end
        if (otp_wr_stb) begin
            stb_count <= stb_count + 1;
        end
    end

    // --------------------------------------------------------
    // Checking and closing
    // --------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            errors++;
        end
    endtask

    task automatic results();
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wait_boot(input logic [2:0] m);
        int k;
        k = 0;
        while (boot_start !== 1'b1 && k < 60) begin
            @(negedge core_clk);
            k++;
        end
        chk("boot", {31'h0, boot_start}, 32'h1);
        chk("mode", {29'h0, boot_mode_latched}, {29'h0, m});
        if (boot_start !== 1'b1) results();
    endtask

    initial begin
        errors = 0;
        n_checks = 0;
        reset = 1'b1;
        rst_n = 1'b0;
        pll_lock = 1'b1;
        boot_mode = 3'h5;
        chip_tdo = 1'b1;
        sec_reg = 32'h0;
        pin_in = 32'hc3a5_0f96;
        otp_rd_data = 32'h5a5a_1234;
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        rst_n = 1'b1;
        wait_boot(3'h5);
        u_dbg.set_trst(1'b1);
        u_dbg.walk(8'h00, 1);
        u_dbg.dr(32, 32'h0, v);
        chk("id_after_reset", v, ID_EXP);
        u_dbg.ir(`JTID_INS_IDCODE, v);
        chk("ir_capture", v, 32'h1);
        u_dbg.dr(32, 32'h0, v);
        chk("idcode", v, ID_EXP);
        for (int u = 0; u < 2; u++) begin
            @(negedge core_clk);
            sec_reg = u ? 32'hd2c0_0000 : 32'h0;
            u_dbg.ir(`JTID_INS_USERCODE, v);
            u_dbg.dr(32, 32'h0, v);
            chk("usercode", v, {sec_reg[31:22], 4'h0, `JTID_DEF_REV});
        end
        for (int c = 6; c < 16; c++) begin
            u_dbg.ir(c[3:0], v);
            u_dbg.dr(8, 32'h9b, v);
            chk("bypass", v, 32'h36);
        end
        u_dbg.ir(`JTID_INS_SAMPLE, v);
        u_dbg.dr(32, 32'h0, v);
        chk("sample", v, pin_in);
        u_dbg.ir(`JTID_INS_EXTEST, v);
        u_dbg.dr(32, 32'h1234_5678, v);
        repeat (8) @(negedge core_clk);
        chk("pin_out", pin_out, 32'h1234_5678);
        chk("pin_oe", {31'h0, pin_test_oe}, 32'h1);
        u_dbg.ir(`JTID_INS_CHIP, v);
        n0 = chip_rises;
        u_dbg.dr(8, 32'h0, v);
        chk("chip_path", v, 32'hff);
        repeat (2) @(negedge core_clk);
        chk("chip_clocks", chip_rises - n0, 32'h0d);
        chk("chip_trst", {31'h0, chip_tap.trst_n}, 32'h1);
        u_dbg.ir(`JTID_INS_OTP, v);
        u_dbg.dr(32, 32'hdead_beef, v);
        repeat (8) @(negedge core_clk);
        chk("otp_read", v, otp_rd_data);
        chk("otp_write", otp_wr_data, 32'hdead_beef);
        chk("otp_rd_en", {31'h0, otp_rd_en}, 32'h1);
        chk("otp_strobe", stb_count, 32'h1);
        sec_reg = 32'h0000_2000;
        u_dbg.ir(`JTID_INS_OTP, v);
        u_dbg.dr(8, 32'h9b, v);
        chk("otp_blocked", v, 32'h36);
        chk("otp_no_write", stb_count, 32'h1);
        chk("otp_rd_off", {31'h0, otp_rd_en}, 32'h0);
        @(negedge core_clk);
        sec_reg = 32'h1;
        u_dbg.dr(8, 32'h9b, v);
        chk("port_locked", v, 32'h0);
        @(negedge core_clk);
        sec_reg = 32'h0;
        u_dbg.walk(8'h00, 1);
        u_dbg.set_trst(1'b0);
        u_dbg.dr(8, 32'h9b, v);
        chk("trst_quiet", v, 32'h0);
        u_dbg.set_trst(1'b1);
        u_dbg.walk(8'h00, 1);
        u_dbg.dr(32, 32'h0, v);
        chk("trst_idcode", v, ID_EXP);
        @(negedge core_clk);
        pll_lock = 1'b0;
        boot_mode = 3'h2;
        rst_n = 1'b0;
        #1;
        chk("chip_rst", {31'h0, chip_rst}, 32'h1);
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (12) @(negedge core_clk);
        chk("no_early_boot", {31'h0, boot_start}, 32'h0);
        pll_lock = 1'b1;
        wait_boot(3'h2);
        results();
    end
endmodule
`default_nettype wire
